// >>> hw/ide_mode_regs.svh
// Offsets, field positions, reset values and fixed port addresses of the
// two-channel disk controller mode logic and of its host-side controller.
// Assumes it is included by bare name from the package and the modules.
`ifndef IDE_MODE_REGS_SVH
`define IDE_MODE_REGS_SVH

// ---------------------------------------------------------------------------
// Device configuration space
// ---------------------------------------------------------------------------
`define CFG_ID_OFS        8'h00
`define CFG_CMD_OFS       8'h04
`define CFG_CLASS_OFS     8'h08
`define CFG_BAR_FIRST_OFS 8'h10
`define CFG_BAR_LAST_OFS  8'h1C
`define CFG_INTR_OFS      8'h3C
`define CMD_IO_EN_BIT     0
`define PI_MODE_PRI_BIT   0
`define PI_CAP_PRI_BIT    1
`define PI_MODE_SEC_BIT   2
`define PI_CAP_SEC_BIT    3
`define PI_BYTE_LSB       8
`define CLASS_BASE        8'h01
`define CLASS_SUB         8'h01
`define REV_ID            8'h00
// Arbitrary identity value, names no real maker or part.
`define DEV_ID_VAL        32'h1234_5678
`define INTR_PIN_INTA     8'h01
`define MODE_RST          2'h0
`define CAP_BITS          2'h3
`define FREEZE_LEGACY_BAR 1'h1
`define BAR_IO_FLAG       32'h0000_0001
`define BAR_CMD_MASK      32'hFFFF_FFF8
`define BAR_CTL_MASK      32'hFFFF_FFFC

// ---------------------------------------------------------------------------
// Fixed legacy resources
// ---------------------------------------------------------------------------
`define LEG_PRI_CMD       16'h01F0
`define LEG_PRI_CTL       16'h03F6
`define LEG_SEC_CMD       16'h0170
`define LEG_SEC_CTL       16'h0376
`define CTL_BYTE_OFS      2'h2

// ---------------------------------------------------------------------------
// Host controller APB registers
// ---------------------------------------------------------------------------
`define H_CTRL_OFS        12'h000
`define H_ADDR_OFS        12'h004
`define H_WDATA_OFS       12'h008
`define H_RDATA_OFS       12'h00C
`define H_STATUS_OFS      12'h010
`define H_INT_STAT_OFS    12'h014
`define H_INT_MASK_OFS    12'h018
`define CTRL_GO_BIT       0
`define CTRL_IO_BIT       1
`define CTRL_WE_BIT       2
`define EV_DONE_BIT       0
`define EV_IRQ_PRI_BIT    1
`define EV_IRQ_SEC_BIT    2
`define EV_INTX_BIT       3

`endif

// >>> hw/ide_mode_pkg.sv
// Types shared by the device end and the host end of the mode logic.
// Assumes the register header is on the include path.
`include "ide_mode_regs.svh"

package ide_mode_pkg;

  // -------------------------------------------------------------------------
  // Device state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic             io_en;
    logic [1:0]       mode;
    logic [3:0][31:0] bar;
    logic             cfg_ack;
    logic             io_busy;
    logic             io_ack;
    logic             io_hit;
    logic [31:0]      rdata;
    logic             acc_valid;
    logic             acc_we;
    logic             acc_chan;
    logic             acc_ctl;
    logic [2:0]       acc_ofs;
    logic [7:0]       acc_wdata;
    logic [1:0]       irq_out;
    logic [1:0]       irq_oe_n;
    logic             intx_out;
    logic             intx_oe_n;
  } dev_regs_t;

  // -------------------------------------------------------------------------
  // Host state
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_CFG, H_IO} host_state_t;

  typedef struct packed {
    host_state_t st;
    logic        kind_io;
    logic        we;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } host_regs_t;

endpackage : ide_mode_pkg

// >>> hw/ide_mode_if.sv
// Link between the host bridge side and the disk controller function.
// Both ends run on the same pclk; tristate lines travel as value and enable pairs that the host end decodes.
`timescale 1ns/10ps

interface ide_mode_if;
  logic        cfg_req;
  logic        io_req;
  logic        req_we;
  logic [15:0] req_addr;
  logic [31:0] req_wdata;
  logic        cfg_ack;
  logic        io_ack;
  logic        io_hit;
  logic [31:0] rdata;
  logic [1:0]  irq_out;
  logic [1:0]  irq_oe_n;
  logic        intx_out;
  logic        intx_oe_n;

  modport dev (
    input  cfg_req, io_req, req_we, req_addr, req_wdata,
    output cfg_ack, io_ack, io_hit, rdata, irq_out, irq_oe_n, intx_out, intx_oe_n
  );

  modport host (
    output cfg_req, io_req, req_we, req_addr, req_wdata,
    input  cfg_ack, io_ack, io_hit, rdata, irq_out, irq_oe_n, intx_out, intx_oe_n
  );
endinterface : ide_mode_if

// >>> hw/ide_port_decoder.sv
// Address decode for one channel: fixed legacy ports or relocated ports.
// Assumes the address and base registers are stable in the calling cycle.
`timescale 1ns/10ps
`include "ide_mode_regs.svh"

module ide_port_decoder #(
  parameter logic [15:0] LEG_CMD = `LEG_PRI_CMD,
  parameter logic [15:0] LEG_CTL = `LEG_PRI_CTL
) (
  input  wire logic        io_en,
  input  wire logic        native,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] bar_cmd,
  input  wire logic [31:0] bar_ctl,
  output      logic        hit_cmd,
  output      logic        hit_ctl
);

  logic leg_cmd;
  logic leg_ctl;
  logic nat_cmd;
  logic nat_ctl;

  // Legacy decode ignores the base registers entirely.
  assign leg_cmd = addr[15:3] == LEG_CMD[15:3];
  assign leg_ctl = addr == LEG_CTL;
  // Only byte 2 of the relocated control window is claimed.
  assign nat_cmd = addr[15:3] == bar_cmd[15:3];
  assign nat_ctl = (addr[15:2] == bar_ctl[15:2]) && (addr[1:0] == `CTL_BYTE_OFS);

  // Nothing is claimed while the function is disabled.
  assign hit_cmd = io_en && (native ? nat_cmd : leg_cmd);
  assign hit_ctl = io_en && (native ? nat_ctl : leg_ctl);

endmodule : ide_port_decoder

// >>> hw/ide_mode_dev.sv
// Device end: configuration registers, per-channel decode source and
// interrupt routing of a two-channel disk controller function.
// Assumes the host holds each request until its acknowledge, and that the
// channel register logic answers ata_rdata combinationally from acc_*.
`timescale 1ns/10ps
`include "ide_mode_regs.svh"

module ide_mode_dev (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  ide_mode_if.dev         link,
  input  wire logic [1:0] chan_irq,
  input  wire logic [7:0] ata_rdata,
  output      logic       acc_valid,
  output      logic       acc_we,
  output      logic       acc_chan,
  output      logic       acc_ctl,
  output      logic [2:0] acc_ofs,
  output      logic [7:0] acc_wdata,
  output      logic [1:0] mode,
  output      logic       io_en
);
  import ide_mode_pkg::*;

  // -------------------------------------------------------------------------
  // Constants
  // -------------------------------------------------------------------------
  localparam logic [1:0] CAP    = `CAP_BITS;
  localparam logic       FREEZE = `FREEZE_LEGACY_BAR;

  localparam dev_regs_t DEV_RST = '{
    mode:      `MODE_RST,
    irq_oe_n:  2'h3,
    intx_oe_n: 1'h1,
    intx_out:  1'h1,
    default:   '0
  };

  dev_regs_t r;
  dev_regs_t r_nxt;

  logic [1:0] hit_cmd;
  logic [1:0] hit_ctl;
  logic [7:0] prog_if;

  // -------------------------------------------------------------------------
  // Per-channel decode
  // -------------------------------------------------------------------------
  localparam logic [1:0][15:0] LEG_CMD = {`LEG_SEC_CMD, `LEG_PRI_CMD};
  localparam logic [1:0][15:0] LEG_CTL = {`LEG_SEC_CTL, `LEG_PRI_CTL};

  for (genvar ch = 0; ch < 2; ch++) begin : g_dec
    ide_port_decoder #(
      .LEG_CMD (LEG_CMD[ch]),
      .LEG_CTL (LEG_CTL[ch])
    ) u_dec (
      .io_en   (r.io_en),
      .native  (r.mode[ch]),
      .addr    (link.req_addr),
      .bar_cmd (r.bar[2*ch]),
      .bar_ctl (r.bar[2*ch+1]),
      .hit_cmd (hit_cmd[ch]),
      .hit_ctl (hit_ctl[ch])
    );
  end

  // Capability and mode pairs form the reported low nibble.
  assign prog_if = {4'h0, CAP[1], r.mode[1], CAP[0], r.mode[0]};

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    int unsigned k;
    logic        ch;
    logic        frozen;
    k      = 0;
    ch     = 1'b0;
    frozen = 1'b0;
    r_nxt  = r;

    // Configuration cycle: acknowledged one cycle after the request is seen.
    r_nxt.cfg_ack = 1'b0;
    if (link.cfg_req && !r.cfg_ack) begin
      r_nxt.cfg_ack = 1'b1;
      r_nxt.rdata   = '0;
      unique case (link.req_addr[7:0])
        `CFG_ID_OFS:    r_nxt.rdata = `DEV_ID_VAL;
        `CFG_CMD_OFS:   r_nxt.rdata = {31'h0000_0000, r.io_en};
        `CFG_CLASS_OFS: r_nxt.rdata = {`CLASS_BASE, `CLASS_SUB, prog_if, `REV_ID};
        `CFG_INTR_OFS:  r_nxt.rdata = {16'h0000, `INTR_PIN_INTA, 8'h00};
        default: begin
          if (link.req_addr[7:0] >= `CFG_BAR_FIRST_OFS &&
              link.req_addr[7:0] <= `CFG_BAR_LAST_OFS &&
              link.req_addr[1:0] == 2'h0) begin
            k      = 32'(link.req_addr[3:2]);
            ch     = link.req_addr[3];
            frozen = FREEZE && !r.mode[ch];
            // A frozen legacy base reads zero; it is never decoded anyway.
            r_nxt.rdata = frozen ? '0 : r.bar[k];
          end
        end
      endcase
      if (link.req_we) begin
        if (link.req_addr[7:0] == `CFG_CMD_OFS) begin
          r_nxt.io_en = link.req_wdata[`CMD_IO_EN_BIT];
        end
        if (link.req_addr[7:0] == `CFG_CLASS_OFS) begin
          // Fixed-mode channels keep their mode.
          if (CAP[0]) begin
            r_nxt.mode[0] = link.req_wdata[`PI_BYTE_LSB + `PI_MODE_PRI_BIT];
          end
          if (CAP[1]) begin
            r_nxt.mode[1] = link.req_wdata[`PI_BYTE_LSB + `PI_MODE_SEC_BIT];
          end
        end
        if (k != 0 || link.req_addr[7:0] == `CFG_BAR_FIRST_OFS) begin
          // Writes to a frozen legacy base are dropped.
          if (!frozen) begin
            r_nxt.bar[k] = (link.req_wdata &
                            (k[0] ? `BAR_CTL_MASK : `BAR_CMD_MASK)) | `BAR_IO_FLAG;
          end
        end
      end
    end

    // IO cycle: decode in the taken cycle with the mode as it stands, so a
    // mode written earlier applies from the next access on.
    r_nxt.acc_valid = 1'b0;
    r_nxt.io_ack    = 1'b0;
    if (link.io_req && !r.io_busy) begin
      r_nxt.io_busy   = 1'b1;
      r_nxt.io_hit    = |{hit_cmd, hit_ctl};
      r_nxt.acc_valid = |{hit_cmd, hit_ctl};
      r_nxt.acc_we    = link.req_we;
      r_nxt.acc_chan  = hit_cmd[1] || hit_ctl[1];
      r_nxt.acc_ctl   = |hit_ctl;
      r_nxt.acc_ofs   = link.req_addr[2:0];
      r_nxt.acc_wdata = link.req_wdata[7:0];
    end else if (r.io_busy && !r.io_ack) begin
      r_nxt.io_ack = 1'b1;
      r_nxt.rdata  = (r.io_hit && !r.acc_we) ? {24'h00_0000, ata_rdata} : '0;
    end else if (r.io_ack) begin
      r_nxt.io_busy = 1'b0;
    end

    // Interrupt routing follows the same mode bits as the decode.
    // The legacy lines are separate pins of this function.
    for (int c = 0; c < 2; c++) begin
      r_nxt.irq_out[c]  = chan_irq[c];
      // Driven only when enabled and legacy, else tristated.
      r_nxt.irq_oe_n[c] = !(r.io_en && !r.mode[c]);
    end
    // Native channels share INTx, open drain, pulled low to assert.
    r_nxt.intx_out  = 1'b0;
    r_nxt.intx_oe_n = !(r.io_en && |(r.mode & chan_irq));
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= DEV_RST;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign link.cfg_ack   = r.cfg_ack;
  assign link.io_ack    = r.io_ack;
  assign link.io_hit    = r.io_hit;
  assign link.rdata     = r.rdata;
  assign link.irq_out   = r.irq_out;
  assign link.irq_oe_n  = r.irq_oe_n;
  assign link.intx_out  = r.intx_out;
  assign link.intx_oe_n = r.intx_oe_n;
  assign acc_valid      = r.acc_valid;
  assign acc_we         = r.acc_we;
  assign acc_chan       = r.acc_chan;
  assign acc_ctl        = r.acc_ctl;
  assign acc_ofs        = r.acc_ofs;
  assign acc_wdata      = r.acc_wdata;
  assign mode           = r.mode;
  assign io_en          = r.io_en;

endmodule : ide_mode_dev

// >>> hw/ide_mode_host.sv
// Host end: an APB slave through which firmware issues configuration and
// IO cycles to the disk controller function and watches its interrupts.
// Assumes firmware polls or takes the interrupt before the next order.
`timescale 1ns/10ps
`include "ide_mode_regs.svh"

module ide_mode_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        irq,
  ide_mode_if.host         link
);
  import ide_mode_pkg::*;

  localparam host_regs_t HOST_RST = '{st: H_IDLE, default: '0};

  host_regs_t r;
  host_regs_t r_nxt;

  always_comb begin
    logic       acc;
    logic [3:0] ev;
    logic [3:0] clr;
    acc   = psel && penable && !r.pready;
    ev    = '0;
    clr   = '0;
    r_nxt = r;

    // Pins from the device pass two flops before anything looks at them.
    r_nxt.s1 = {!link.intx_oe_n && !link.intx_out,
                !link.irq_oe_n[1] && link.irq_out[1],
                !link.irq_oe_n[0] && link.irq_out[0]};
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    ev[`EV_IRQ_PRI_BIT] = r.s2[0] && !r.s3[0];
    ev[`EV_IRQ_SEC_BIT] = r.s2[1] && !r.s3[1];
    ev[`EV_INTX_BIT]    = r.s2[2] && !r.s3[2];

    // APB access phase: one wait state, answered from flops.
    r_nxt.pready  = acc;
    r_nxt.pslverr = 1'b0;
    r_nxt.prdata  = '0;
    if (acc) begin
      unique case (paddr)
        `H_CTRL_OFS: begin
          // Firmware starts a configuration or IO cycle, read or write, while idle.
          if (pwrite && pwdata[`CTRL_GO_BIT] && r.st == H_IDLE) begin
            r_nxt.kind_io = pwdata[`CTRL_IO_BIT];
            r_nxt.we      = pwdata[`CTRL_WE_BIT];
            r_nxt.st      = pwdata[`CTRL_IO_BIT] ? H_IO : H_CFG;
          end
        end
        `H_ADDR_OFS:     if (pwrite) r_nxt.addr  = pwdata[15:0];
                         else r_nxt.prdata = {16'h0000, r.addr};
        `H_WDATA_OFS:    if (pwrite) r_nxt.wdata = pwdata;
                         else r_nxt.prdata = r.wdata;
        `H_RDATA_OFS:    r_nxt.prdata = r.rdata;
        `H_STATUS_OFS:   r_nxt.prdata = {25'h000_0000, r.s3, 2'h0, r.hit, r.st != H_IDLE};
        `H_INT_STAT_OFS: if (!pwrite) begin
                           r_nxt.prdata = {28'h000_0000, r.int_stat};
                           clr          = 4'hF;
                         end
        `H_INT_MASK_OFS: if (pwrite) r_nxt.int_mask = pwdata[3:0];
                         else r_nxt.prdata = {28'h000_0000, r.int_mask};
        default:         r_nxt.pslverr = 1'b1;
      endcase
    end

    // Link cycle: request held until the device acknowledges it.
    unique case (r.st)
      H_IDLE: ;
      H_CFG: if (link.cfg_ack) begin
        r_nxt.st               = H_IDLE;
        r_nxt.rdata            = link.rdata;
        r_nxt.hit              = 1'b1;
        ev[`EV_DONE_BIT]       = 1'b1;
      end
      H_IO: if (link.io_ack) begin
        r_nxt.st               = H_IDLE;
        r_nxt.rdata            = link.rdata;
        r_nxt.hit              = link.io_hit;
        ev[`EV_DONE_BIT]       = 1'b1;
      end
    endcase

    // A new event wins over a clearing read in the same cycle.
    r_nxt.int_stat = (r.int_stat & ~clr) | ev;
    r_nxt.irq      = |(r_nxt.int_stat & r_nxt.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= HOST_RST;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign irq            = r.irq;
  assign link.cfg_req   = r.st == H_CFG;
  assign link.io_req    = r.st == H_IO;
  assign link.req_we    = r.we;
  assign link.req_addr  = r.addr;
  assign link.req_wdata = r.wdata;

endmodule : ide_mode_host

// >>> dv/ide_mode_monitor.sv
// Checker on the link between the host end and the device end.
// Assumes it is instantiated beside the interface, all on pclk.
`timescale 1ns/10ps

module ide_mode_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cfg_req,
  input wire logic        io_req,
  input wire logic        cfg_ack,
  input wire logic        io_ack,
  input wire logic        io_hit,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  irq_oe_n,
  input wire logic        intx_out,
  input wire logic        intx_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------------------
  a_cfg_answer_time: assert property ($rose(cfg_req) |=> cfg_ack)
    else $error("cfg ack late");
  a_cfg_ack_pulse: assert property (cfg_ack |=> !cfg_ack)
    else $error("cfg ack too long");
  a_cfg_ack_cause: assert property (cfg_ack |-> cfg_req && !io_ack)
    else $error("cfg ack without request");
  a_io_answer_time: assert property ($rose(io_req) |-> ##2 io_ack)
    else $error("io ack late");
  a_io_ack_pulse: assert property (io_ack |=> !io_ack)
    else $error("io ack too long");
  a_io_req_hold: assert property (io_req && !io_ack |=> io_req)
    else $error("io request dropped early");
  // A miss stands in for a master abort, so it must carry no stale data.
  a_io_miss_zero: assert property (io_ack && !io_hit |-> rdata == 32'h0000_0000)
    else $error("unclaimed access returned data");

  // ------------------------------------------------------------------------
  // Interrupt pins
  // ------------------------------------------------------------------------
  a_legacy_no_intx: assert property (irq_oe_n == 2'b00 |-> intx_oe_n)
    else $error("inta asserted with both channels legacy");
  a_intx_low_run: assert property ($past(presetn) |-> !intx_out)
    else $error("inta output not low");

  c_io_hit: cover property (io_ack && io_hit);
  c_io_miss: cover property (io_ack && !io_hit);
  c_intx_on: cover property (!intx_oe_n);
  c_legacy_on: cover property (irq_oe_n == 2'b00);
endmodule : ide_mode_monitor

// >>> dv/ide_channel_mode_router_tb_top.sv
// Bench: firmware-style APB orders through the host end to the device end.
// Assumes the register header is on the include path.
`timescale 1ns/10ps
`include "ide_mode_regs.svh"

module ide_channel_mode_router_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [1:0]  chan_irq, mode;
  logic [7:0]  ata_rdata, acc_wdata;
  logic [2:0]  acc_ofs;
  logic        acc_valid, acc_we, acc_chan, acc_ctl, io_en, h;
  int          err_count, compares, acc_count;

  ide_mode_if u_ide_mode_if ();
  // The function sits straight on the host end with no bridge between.
  ide_mode_dev u_ide_mode_dev (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .link(u_ide_mode_if.dev), .chan_irq(chan_irq), .ata_rdata(ata_rdata),
    .acc_valid(acc_valid), .acc_we(acc_we), .acc_chan(acc_chan), .acc_ctl(acc_ctl),
    .acc_ofs(acc_ofs), .acc_wdata(acc_wdata), .mode(mode), .io_en(io_en));
  ide_mode_host u_ide_mode_host (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(u_ide_mode_if.host));
  ide_mode_monitor u_ide_mode_monitor (.pclk(pclk), .presetn(presetn),
    .cfg_req(u_ide_mode_if.cfg_req), .io_req(u_ide_mode_if.io_req),
    .cfg_ack(u_ide_mode_if.cfg_ack), .io_ack(u_ide_mode_if.io_ack),
    .io_hit(u_ide_mode_if.io_hit), .rdata(u_ide_mode_if.rdata),
    .irq_oe_n(u_ide_mode_if.irq_oe_n), .intx_out(u_ide_mode_if.intx_out),
    .intx_oe_n(u_ide_mode_if.intx_oe_n));

  // ------------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Orders one link cycle and polls busy; the watchdog bounds the poll.
  task automatic op(input logic io, input logic we, input logic [15:0] a,
                    input logic [31:0] wd, output logic [31:0] rd, output logic hit);
    logic [31:0] st;
    apb(1'b1, `H_ADDR_OFS, {16'h0000, a}, st);
    apb(1'b1, `H_WDATA_OFS, wd, st);
    apb(1'b1, `H_CTRL_OFS, {29'h0, we, io, 1'b1}, st);
    st = 32'h0000_0001;
    while (st[0] !== 1'b0) apb(1'b0, `H_STATUS_OFS, 32'h0000_0000, st);
    hit = st[1];
    apb(1'b0, `H_RDATA_OFS, 32'h0000_0000, rd);
  endtask : op

  task automatic cw(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        x;
    op(1'b0, 1'b1, {8'h00, a}, wd, r, x);
  endtask : cw

  task automatic cr(input logic [7:0] a, output logic [31:0] r);
    logic x;
    op(1'b0, 1'b0, {8'h00, a}, 32'h0000_0000, r, x);
  endtask : cr

  task automatic probe(input logic [15:0] a, input logic eh, input logic ec);
    logic [31:0] r;
    logic        ht;
    op(1'b1, 1'b0, a, 32'h0000_0000, r, ht);
    chk("io_hit", {31'h0, eh}, {31'h0, ht});
    chk("io_data", eh ? 32'h0000_00A5 : 32'h0000_0000, r);
    if (eh) begin
      chk("acc_chan", {31'h0, ec}, {31'h0, acc_chan});
      chk("acc_ofs", {29'h0, a[2:0]}, {29'h0, acc_ofs});
    end
  endtask : probe

  task conclude;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Each claimed access pulses the channel strobe for exactly one cycle.
  always @(posedge pclk) begin
    if (acc_valid === 1'b1) acc_count++;
  end

  initial begin
    #60000;
    err_count++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    chan_irq = 2'b11;
    ata_rdata = 8'hA5;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("irq_oe_n", 32'h3, {30'h0, u_ide_mode_if.irq_oe_n});
    chk("intx_oe_n", 32'h1, {31'h0, u_ide_mode_if.intx_oe_n});
    cr(`CFG_CMD_OFS, d);
    chk("io_en", 32'h0, d);
    probe(16'h01F0, 1'b0, 1'b0);
    chan_irq <= 2'b00;
    cr(`CFG_CLASS_OFS, d);
    chk("class", 32'h0101_0A00, {d[31:16], 4'h0, d[11:0]});
    cw(`CFG_CMD_OFS, 32'h0000_0001);
    chk("io_en", 32'h1, {31'h0, io_en});
    chk("irq_oe_n", 32'h0, {30'h0, u_ide_mode_if.irq_oe_n});
    cw(8'h10, 32'h0000_1000);
    cr(8'h10, d);
    chk("bar_frozen", 32'h0, d);
    probe(16'h01F0, 1'b1, 1'b0);
    probe(16'h01F7, 1'b1, 1'b0);
    probe(16'h01F8, 1'b0, 1'b0);
    probe(16'h03F6, 1'b1, 1'b0);
    chk("acc_ctl", 32'h1, {31'h0, acc_ctl});
    probe(16'h0170, 1'b1, 1'b1);
    probe(16'h0376, 1'b1, 1'b1);
    probe(16'h1000, 1'b0, 1'b0);
    op(1'b1, 1'b1, 16'h0172, 32'h0000_005A, d, h);
    chk("acc_wdata", 32'h15A, {23'h0, acc_we, acc_wdata});
    cw(`CFG_CLASS_OFS, 32'h0000_0500);
    chk("mode", 32'h3, {30'h0, mode});
    probe(16'h0170, 1'b0, 1'b0);
    cr(`CFG_CLASS_OFS, d);
    chk("mode_bits", 32'hF, {28'h0, d[11:8]});
    cw(8'h10, 32'h0000_1000);
    cw(8'h14, 32'h0000_2000);
    cw(8'h18, 32'h0000_3000);
    cw(8'h1C, 32'h0000_4003);
    cr(8'h10, d);
    chk("bar_cmd", 32'h0000_1001, d);
    cr(8'h1C, d);
    chk("bar_ctl", 32'h0000_4001, d);
    probe(16'h1007, 1'b1, 1'b0);
    probe(16'h1008, 1'b0, 1'b0);
    probe(16'h2002, 1'b1, 1'b0);
    probe(16'h3000, 1'b1, 1'b1);
    probe(16'h4002, 1'b1, 1'b1);
    probe(16'h01F0, 1'b0, 1'b0);
    probe(16'h0376, 1'b0, 1'b0);
    chan_irq <= 2'b01;
    repeat (3) @(posedge pclk);
    chk("intx_oe_n", 32'h0, {31'h0, u_ide_mode_if.intx_oe_n});
    chk("irq_oe_n", 32'h3, {30'h0, u_ide_mode_if.irq_oe_n});
    apb(1'b1, `H_INT_MASK_OFS, 32'h0000_0008, d);
    repeat (4) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, `H_INT_STAT_OFS, 32'h0000_0000, d);
    chk("stat_intx", 32'h1, {31'h0, d[3]});
    chan_irq <= 2'b00;
    repeat (6) @(posedge pclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    cw(`CFG_CLASS_OFS, 32'h0000_0000);
    chan_irq <= 2'b10;
    repeat (3) @(posedge pclk);
    chk("leg_pins", 32'h18, {27'h0, u_ide_mode_if.intx_oe_n, u_ide_mode_if.irq_out,
        u_ide_mode_if.irq_oe_n});
    repeat (4) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b0, `H_INT_STAT_OFS, 32'h0000_0000, d);
    chk("stat_sec", 32'h1, {31'h0, d[2]});
    apb(1'b0, 12'h01C, 32'h0000_0000, d);
    chk("pslverr", 32'h1, {31'h0, serr});
    chk("acc_valid", 32'd10, acc_count);
    conclude();
  end
endmodule : ide_channel_mode_router_tb_top
